// >>> core/pcg_gate_cell.sv
// glitch-free clock gate: enable latched while the clock is low
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_cell (
    // clock and enable
    input wire logic clk_i,
    input wire logic en_i,
    // gated clock
    output logic gclk_o
);
    logic en_lat;
    // transparent-low latch keeps the enable still while clk is high
    always_latch begin
        if (!clk_i) begin
            en_lat <= en_i;
        end
    end
    assign gclk_o = clk_i & en_lat;
endmodule
`default_nettype wire

// >>> core/pcg_pkg.sv
// package: register map, field positions and carrier types of the peripheral clock gate block
package pcg_pkg;
    // register byte offsets
    localparam logic [11:0] PCG_OFS_RUN_SET1 = 12'h104;
    localparam logic [11:0] PCG_OFS_RUN_SET2 = 12'h108;
    localparam logic [11:0] PCG_OFS_SLP_SET1 = 12'h114;
    localparam logic [11:0] PCG_OFS_SLP_SET2 = 12'h118;
    localparam logic [11:0] PCG_OFS_DSL_SET1 = 12'h124;
    localparam logic [11:0] PCG_OFS_DSL_SET2 = 12'h128;
    localparam logic [11:0] PCG_OFS_RUN_CFG = 12'h060;
    localparam logic [11:0] PCG_OFS_STATUS = 12'h070;
    // writable-bit masks and gate register reset value
    localparam logic [31:0] PCG_SET1_MASK = 32'h0707_1013;
    localparam logic [31:0] PCG_SET2_MASK = 32'h0000_00FF;
    localparam logic [31:0] PCG_GATE_RESET = 32'h0000_0000;
    // set-1 field positions
    localparam int PCG_B_ASYNC_A = 0;
    localparam int PCG_B_ASYNC_B = 1;
    localparam int PCG_B_SYNC_SER = 4;
    localparam int PCG_B_TWO_WIRE = 12;
    localparam int PCG_B_CNT_A = 16;
    localparam int PCG_B_CNT_C = 18;
    localparam int PCG_B_CMP_A = 24;
    localparam int PCG_B_CMP_C = 26;
    // run_clock_configuration field
    localparam int PCG_B_AUTO_GATE = 27;
    // number of gated units: 10 from set 1, unit 10 tied off, 8 ports from set 2
    localparam int PCG_N_UNITS = 19;
    // power modes
    typedef enum logic [2:0] {
        PCG_MODE_RUN = 3'h1,
        PCG_MODE_SLEEP = 3'h2,
        PCG_MODE_DEEP = 3'h4
    } pcg_mode_t;
    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pcg_apb_req_t;
    // apb answer bundle
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pcg_apb_rsp_t;
endpackage

// >>> core/pcg_top.sv
// peripheral clock gating control: apb registers, mode copy select, clock gates, fault check
`timescale 1ns/1ps
`default_nettype none
module pcg_top
    import pcg_pkg::*;
#(
    parameter int N_UNITS = PCG_N_UNITS
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // apb slave for the gate registers
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    // power mode from the mode controller, same clock
    input wire logic SLEEP_I,
    input wire logic DEEP_SLEEP_I,
    // peripheral access check, same clock
    input wire logic PERIPH_ACCESS_I,
    input wire logic [4:0] PERIPH_SEL_I,
    output logic PERIPH_FAULT_O,
    // per-unit enables and gated clocks
    output logic [N_UNITS-1:0] UNIT_EN_O,
    output logic [N_UNITS-1:0] UNIT_CLK_O
);
    typedef struct packed {
        logic [31:0] run1;
        logic [31:0] run2;
        logic [31:0] slp1;
        logic [31:0] slp2;
        logic [31:0] dsl1;
        logic [31:0] dsl2;
        logic auto_gate;
        pcg_mode_t mode;
        logic [N_UNITS-1:0] en;
        logic [31:0] rdata;
        logic slverr;
        logic fault;
    } pcg_state_t;

    pcg_state_t st_q;
    pcg_state_t st_d;
    pcg_apb_req_t req;
    pcg_apb_rsp_t rsp;

    // gather the live set-1 and set-2 bits into one unit vector
    function automatic logic [N_UNITS-1:0] pcg_units(input logic [31:0] s1, input logic [31:0] s2);
        logic [N_UNITS-1:0] u;
        u = '0;
        u[0] = s1[PCG_B_ASYNC_A];
        u[1] = s1[PCG_B_ASYNC_B];
        u[2] = s1[PCG_B_SYNC_SER];
        u[3] = s1[PCG_B_TWO_WIRE];
        u[6:4] = s1[PCG_B_CNT_C:PCG_B_CNT_A];
        u[9:7] = s1[PCG_B_CMP_C:PCG_B_CMP_A];
        u[10] = 1'b0;
        u[18:11] = s2[7:0];
        return u;
    endfunction

    assign req.psel = PSEL_I;
    assign req.penable = PENABLE_I;
    assign req.pwrite = PWRITE_I;
    assign req.paddr = PADDR_I;
    assign req.pwdata = PWDATA_I;

    // which register a bus address names; one bit per register
    typedef struct packed {
        logic run1;
        logic run2;
        logic slp1;
        logic slp2;
        logic dsl1;
        logic dsl2;
        logic cfg;
        logic status;
    } pcg_hit_t;

    // address decode, shared by the read mux and the write path
    function automatic pcg_hit_t pcg_decode(input logic [11:0] a);
        pcg_hit_t h;
        h = '0;
        h.run1 = (a == PCG_OFS_RUN_SET1);
        h.slp1 = (a == PCG_OFS_SLP_SET1);
        h.run2 = (a == PCG_OFS_RUN_SET2);
        h.slp2 = (a == PCG_OFS_SLP_SET2);
        h.dsl1 = (a == PCG_OFS_DSL_SET1);
        h.dsl2 = (a == PCG_OFS_DSL_SET2);
        h.cfg = (a == PCG_OFS_RUN_CFG);
        h.status = (a == PCG_OFS_STATUS);
        return h;
    endfunction

    // reserved bits never reach the gate flops
    function automatic logic [31:0] pcg_keep(input logic [31:0] d, input logic [31:0] m);
        return d & m;
    endfunction

    // unit gated off, or nothing behind the select, answers with a fault
    function automatic logic pcg_fault(input logic [4:0] s, input logic [N_UNITS-1:0] e);
        logic f;
        f = 1'b1;
        if (s < 5'(N_UNITS)) begin
            f = ~e[s];
        end
        return f;
    endfunction

    pcg_hit_t hit;
    logic wr_en;
    logic rd_en;
    logic known;
    logic [31:0] rd_mux;
    logic [31:0] sel1;
    logic [31:0] sel2;

    assign hit = pcg_decode(req.paddr);
    assign known = |hit;

    // write lands on the completing access edge, so an abandoned setup changes nothing
    assign wr_en = req.psel & req.penable & req.pwrite;
    // read data captured at setup and held through the zero-wait access phase
    assign rd_en = req.psel & ~req.penable & ~req.pwrite;

    // read mux; an unmapped address reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit.run1) begin
            rd_mux = st_q.run1;
        end
        if (hit.run2) begin
            rd_mux = st_q.run2;
        end
        if (hit.slp1) begin
            rd_mux = st_q.slp1;
        end
        if (hit.slp2) begin
            rd_mux = st_q.slp2;
        end
        if (hit.dsl1) begin
            rd_mux = st_q.dsl1;
        end
        if (hit.dsl2) begin
            rd_mux = st_q.dsl2;
        end
        if (hit.cfg) begin
            rd_mux = {4'h0, st_q.auto_gate, 27'h000_0000};
        end
        if (hit.status) begin
            rd_mux = {10'h000, st_q.mode, st_q.en};
        end
    end

    always_comb begin
        st_d = st_q;
        // only documented gate bits store writes
        if (wr_en) begin
            if (hit.run1) begin
                st_d.run1 = pcg_keep(req.pwdata, PCG_SET1_MASK);
            end
            if (hit.slp1) begin
                st_d.slp1 = pcg_keep(req.pwdata, PCG_SET1_MASK);
            end
            if (hit.dsl1) begin
                st_d.dsl1 = pcg_keep(req.pwdata, PCG_SET1_MASK);
            end
            if (hit.run2) begin
                st_d.run2 = pcg_keep(req.pwdata, PCG_SET2_MASK);
            end
            if (hit.slp2) begin
                st_d.slp2 = pcg_keep(req.pwdata, PCG_SET2_MASK);
            end
            if (hit.dsl2) begin
                st_d.dsl2 = pcg_keep(req.pwdata, PCG_SET2_MASK);
            end
            if (hit.cfg) begin
                st_d.auto_gate = req.pwdata[PCG_B_AUTO_GATE];
            end
        end
        if (rd_en) begin
            st_d.rdata = known ? rd_mux : 32'h0000_0000;
        end
        if (req.psel && !req.penable) begin
            st_d.slverr = ~known;
        end
        // low-power copies only with auto gating on
        if (DEEP_SLEEP_I) begin
            st_d.mode = PCG_MODE_DEEP;
        end else if (SLEEP_I) begin
            st_d.mode = PCG_MODE_SLEEP;
        end else begin
            st_d.mode = PCG_MODE_RUN;
        end
        // copy chosen by mode; run copy without auto gating
        sel1 = st_q.run1;
        sel2 = st_q.run2;
        if (st_q.auto_gate) begin
            unique case (st_q.mode)
                PCG_MODE_SLEEP: begin
                    sel1 = st_q.slp1;
                    sel2 = st_q.slp2;
                end
                PCG_MODE_DEEP: begin
                    sel1 = st_q.dsl1;
                    sel2 = st_q.dsl2;
                end
                default: begin
                    sel1 = st_q.run1;
                    sel2 = st_q.run2;
                end
            endcase
        end
        // enable follows register one cycle later
        st_d.en = pcg_units(sel1, sel2);
        // fault while the addressed unit is unclocked
        st_d.fault = 1'b0;
        if (PERIPH_ACCESS_I) begin
            st_d.fault = pcg_fault(PERIPH_SEL_I, st_q.en);
        end
    end

    // all gates and state clear at reset; mode loads run
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q <= '{
                run1: PCG_GATE_RESET,
                run2: PCG_GATE_RESET,
                slp1: PCG_GATE_RESET,
                slp2: PCG_GATE_RESET,
                dsl1: PCG_GATE_RESET,
                dsl2: PCG_GATE_RESET,
                auto_gate: 1'b0,
                mode: PCG_MODE_RUN,
                en: '0,
                rdata: 32'h0000_0000,
                slverr: 1'b0,
                fault: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp.pready = req.psel & req.penable;
    assign rsp.pslverr = req.psel & req.penable & st_q.slverr;
    assign rsp.prdata = st_q.rdata;
    assign PREADY_O = rsp.pready;
    assign PSLVERR_O = rsp.pslverr;
    assign PRDATA_O = rsp.prdata;
    assign PERIPH_FAULT_O = st_q.fault;
    assign UNIT_EN_O = st_q.en;

    for (genvar g = 0; g < N_UNITS; g++) begin : g_gate
        pcg_gate_cell u_gate (
            .clk_i(CLK_I),
            .en_i(st_q.en[g]),
            .gclk_o(UNIT_CLK_O[g])
        );
    end
endmodule
`default_nettype wire

// >>> verification/pcg_checker_assertions.sv
// checker: bus, gate and fault relations of the clock gate block
`timescale 1ns/1ps
`default_nettype none
module pcg_checker
    import pcg_pkg::*;
#(
    parameter int N_UNITS = PCG_N_UNITS
) (
    input wire logic CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O, PSLVERR_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic SLEEP_I, DEEP_SLEEP_I, PERIPH_ACCESS_I,
    input wire logic [4:0] PERIPH_SEL_I,
    input wire logic PERIPH_FAULT_O,
    input wire logic [N_UNITS-1:0] UNIT_EN_O, UNIT_CLK_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire logic acc = PSEL_I && PENABLE_I;
    wire logic s1 = PADDR_I inside {PCG_OFS_RUN_SET1, PCG_OFS_SLP_SET1, PCG_OFS_DSL_SET1};
    wire logic s2 = PADDR_I inside {PCG_OFS_RUN_SET2, PCG_OFS_SLP_SET2, PCG_OFS_DSL_SET2};
    wire logic hit = PERIPH_ACCESS_I && (PERIPH_SEL_I < 5'(N_UNITS));
    a_reset_gates_off: assert property ($past(!RST_B_I) |-> UNIT_EN_O == '0)
        else $error("gate enables not clear after reset");
    a_gclk_low_phase: assert property (UNIT_CLK_O == '0)
        else $error("gated clock high while clock low");
    a_gclk_follows_en: assert property (@(negedge CLK_I) disable iff (!RST_B_I)
        UNIT_CLK_O == $past(UNIT_EN_O)) else $error("gated clock differs from enable");
    a_fault_when_off: assert property (hit && !UNIT_EN_O[PERIPH_SEL_I] |=> PERIPH_FAULT_O)
        else $error("access to unclocked unit not faulted");
    a_no_fault_on: assert property (hit && UNIT_EN_O[PERIPH_SEL_I] |=> !PERIPH_FAULT_O)
        else $error("access to clocked unit faulted");
    a_fault_has_cause: assert property (PERIPH_FAULT_O |-> $past(PERIPH_ACCESS_I))
        else $error("fault without access");
    a_set1_rsv_zero: assert property (acc && !PWRITE_I && s1 |->
        (PRDATA_O & ~PCG_SET1_MASK) == '0) else $error("set1 reserved bits not zero");
    a_set2_rsv_zero: assert property (acc && !PWRITE_I && s2 |->
        (PRDATA_O & ~PCG_SET2_MASK) == '0) else $error("set2 reserved bits not zero");
    a_map_no_err: assert property (acc && (s1 || s2) |-> !PSLVERR_O)
        else $error("mapped gate register answered with error");
    a_run_write_en: assert property (acc && PWRITE_I && PADDR_I == PCG_OFS_RUN_SET1
        && !SLEEP_I && !DEEP_SLEEP_I && !$past(SLEEP_I) && !$past(DEEP_SLEEP_I)
        |-> ##2 UNIT_EN_O[1:0] == $past(PWDATA_I[1:0], 2)) else $error("run write not applied");
endmodule
bind pcg_top pcg_checker #(.N_UNITS(N_UNITS)) u_pcg_checker (.*);
`default_nettype wire

// >>> verification/pcg_periph_model.sv
// model of the gated peripherals: issues accesses and counts delivered clock pulses
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model (
    input wire logic clk_i,
    input wire logic [18:0] unit_clk_i,
    input wire logic fault_i,
    output logic access_o,
    output logic [4:0] sel_o
);
    initial begin
        access_o = 1'h0;
        sel_o = 5'h0;
    end
    // one access cycle; the answer comes one cycle later
    task automatic poke(input logic [4:0] s, output logic f);
        @(posedge clk_i);
        access_o <= 1'h1;
        sel_o <= s;
        @(posedge clk_i);
        access_o <= 1'h0;
        // released select shows a changed pattern, never the old one
        sel_o <= ~s;
        #1 f = fault_i;
    endtask
    // high phase sampled mid-way, away from both edges
    task automatic pulses(input logic [4:0] s, output int c);
        c = 0;
        repeat (8) begin
            @(posedge clk_i);
            // an unknown clock counts 16, so it matches no expected count
            #2 c += (unit_clk_i[s] === 1'b1) ? 1 : ((unit_clk_i[s] === 1'b0) ? 0 : 16);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the peripheral clock gate block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst_b, psel, pen, pwr, pready, perr, slp, dsl, acc, flt, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0] sel;
    logic [18:0] en, gclk;
    int n_errors, num_checks, c;
    logic [11:0] ra[7] = '{12'h104, 12'h114, 12'h124, 12'h108, 12'h118, 12'h128, 12'h200};
    logic [31:0] rx[7] = '{32'h0707_1013, 32'h0707_1013, 32'h0707_1013, 32'h0000_00FF,
        32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000};
    pcg_top u_pcg_top (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .PRDATA_O(prdata), .SLEEP_I(slp), .DEEP_SLEEP_I(dsl), .PERIPH_ACCESS_I(acc),
        .PERIPH_SEL_I(sel), .PERIPH_FAULT_O(flt), .UNIT_EN_O(en), .UNIT_CLK_O(gclk));
    pcg_periph_model u_pcg_periph_model (.clk_i(clk), .unit_clk_i(gclk), .fault_i(flt),
        .access_o(acc), .sel_o(sel));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    function automatic logic [18:0] ens(logic [31:0] a, logic [31:0] b);
        return {b[7:0], 1'h0, a[26:24], a[18:16], a[12], a[4], a[1:0]};
    endfunction
    task automatic chk(input logic [31:0] x, input logic [31:0] g, input string nm);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        r = prdata;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (pready !== 1'h1) begin
            n_errors++;
            give_verdict;
        end
    endtask
    task automatic ck_en(input logic [18:0] x);
        repeat (3) @(posedge clk);
        #1 chk({13'h0, x}, {13'h0, en}, "unit_en");
    endtask
    task automatic fault(input logic [4:0] s, input logic x);
        logic f;
        u_pcg_periph_model.poke(s, f);
        chk({31'h0, x}, {31'h0, f}, "periph_fault");
    endtask
    task automatic pulses(input logic [4:0] s, input int x);
        u_pcg_periph_model.pulses(s, c);
        chk(x, c, "unit_clk_pulses");
    endtask
    initial begin
        n_errors = 0;
        num_checks = 0;
        {rst_b, psel, pen, pwr, slp, dsl} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        do_reset;
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, ra[i], 32'h0);
            chk(32'h0, r, "reset_value");
        end
        ck_en(19'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'h1, ra[i], 32'hFFFF_FFFF);
            chk(32'(i == 6), {31'h0, e}, "write_err");
            apb(1'h0, ra[i], 32'h0);
            chk(rx[i], r, "read_data");
            chk(32'(i == 6), {31'h0, e}, "read_err");
        end
        ck_en(ens(32'h0707_1013, 32'hFF));
        // read-modify-write keeps reserved bits as read
        apb(1'h0, 12'h104, 32'h0);
        apb(1'h1, 12'h104, (r & ~32'h0707_1013) | 32'h0000_1010);
        apb(1'h1, 12'h108, 32'h1);
        ck_en(ens(32'h1010, 32'h1));
        fault(5'h0, 1'h1);
        fault(5'h3, 1'h0);
        fault(5'h14, 1'h1);
        pulses(5'h3, 8);
        pulses(5'h0, 0);
        @(posedge clk);
        slp <= 1'h1;
        ck_en(ens(32'h1010, 32'h1));
        apb(1'h1, 12'h060, 32'h0800_0000);
        apb(1'h0, 12'h060, 32'h0);
        chk(32'h0800_0000, r, "run_cfg");
        apb(1'h1, 12'h114, 32'h0100_0002);
        apb(1'h1, 12'h118, 32'h80);
        ck_en(ens(32'h0100_0002, 32'h80));
        apb(1'h1, 12'h124, 32'h0004_0000);
        apb(1'h1, 12'h128, 32'h2);
        dsl <= 1'h1;
        ck_en(ens(32'h0004_0000, 32'h2));
        apb(1'h0, 12'h070, 32'h0);
        chk({10'h0, 3'h4, ens(32'h0004_0000, 32'h2)}, r, "status");
        pulses(5'h6, 8);
        @(posedge clk);
        {slp, dsl} <= 2'h0;
        ck_en(ens(32'h1010, 32'h1));
        do_reset;
        ck_en(19'h0);
        apb(1'h0, 12'h104, 32'h0);
        chk(32'h0, r, "reset_value");
        give_verdict;
    end
endmodule
`default_nettype wire
